// >>> ubd_pkg.sv
/*
  ubd_pkg: register map, field positions, reset values and carrier types
  for the serial baud divider and timer block.
  assumes a 32-bit AXI4-Lite register bus and a single system clock.
*/
package ubd_pkg;
  // line control is kept as a word index; its byte address is four times
  // the index, which is why the bus carries 14 address bits
  localparam logic [11:0] LINE_CTRL_INDEX = 12'hF42;
  localparam logic [13:0] ADDR_LINE_CTRL = {LINE_CTRL_INDEX, 2'b00};
  localparam logic [13:0] ADDR_SEC_CTRL = 14'h0000;
  localparam logic [13:0] ADDR_DIV_HIGH = 14'h0004;
  localparam logic [13:0] ADDR_DIV_LOW = 14'h0008;
  localparam logic [13:0] ADDR_IRQ_STAT = 14'h000C;
  localparam logic [13:0] ADDR_IRQ_MASK = 14'h0010;
  localparam logic [13:0] ADDR_LINE_STAT = 14'h0014;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [7:0] SEC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // secondary control bit positions
  localparam int SEC_TIMER_BIT = 0;
  localparam int SEC_DIVIRQ_BIT = 1;
  // interrupt status bit positions
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_RELOAD_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int OVERSAMPLE = 16;

  // primary line control, bit 7 down to bit 0
  typedef struct packed {
    logic transmit_enable;
    logic receive_enable;
    logic clear_to_send_gate;
    logic parity_on;
    logic parity_select;
    logic send_break;
    logic stop_select;
    logic loopback_on;
  } ubd_line_ctrl_t;

  // divider outputs that travel together
  typedef struct packed {
    logic tick;
    logic bit_tick;
  } ubd_ticks_t;
endpackage

// >>> ubd_divider.sv
/*
  ubd_divider: 16-bit reloading down counter with one-cycle tick, and a
  divide-by-sixteen stage that yields the per-bit strobe.
  assumes divisor is held steady while run is high.
*/
module ubd_divider #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  output ubd_pkg::ubd_ticks_t ticks
);
  logic [WIDTH-1:0] cnt_q; // cycles left before the tick
  logic [3:0] sub_q; // oversample phase
  logic term_w;
  logic [WIDTH-1:0] start_w;
  logic bit_w;

  // zero wraps to all ones plus one step, so it counts 65536
  assign start_w = divisor - {{(WIDTH-1){1'b0}}, 1'b1};
  assign term_w = run && (cnt_q == '0);
  assign bit_w = term_w && (sub_q == 4'hF);

  // reload after the terminal count
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= '0;
      sub_q <= 4'h0;
      ticks <= '0;
    end else begin
      cnt_q <= term_w ? start_w : cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      if (term_w) begin
        sub_q <= sub_q + 4'h1; // sixteen ticks per bit
      end
      ticks.tick <= term_w;
      ticks.bit_tick <= bit_w;
    end
  end
endmodule

// >>> ubd_top.sv
/*
  ubd_top: baud divider, divider timer, line control and interrupt
  registers of a serial port, reached over AXI4-Lite.
  assumes a well-behaved AXI4-Lite master; CTS pin is asynchronous and
  active low; one system clock MCLK with synchronous high reset RST.
  byte addresses are 14 bits, as line control sits high in the map.
*/
module ubd_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CTS_N,
  input wire logic [13:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [13:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic TX_RUN,
  output logic BIT_TICK,
  output logic IRQ
);
  ubd_pkg::ubd_line_ctrl_t line_q; // primary line control
  logic [7:0] sec_q; // secondary control
  logic [7:0] div_hi_q; // divisor high byte
  logic [7:0] div_lo_q; // divisor low byte
  logic [1:0] stat_q; // sticky interrupt status
  logic [1:0] mask_q; // interrupt mask
  logic cts_s1_q; // synchroniser first stage, read only by second
  logic cts_s2_q;
  logic [13:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic [15:0] divisor_w;
  logic port_on_w;
  logic timer_w;
  logic run_w;
  logic wr_go_w;
  logic wr_hit_w;
  logic rd_hit_w;
  logic [31:0] rd_data_w;
  logic [1:0] set_w;
  logic [1:0] clr_w;
  logic tx_ok_w;
  ubd_pkg::ubd_ticks_t ticks_w;

  // word-aligned address decode shared by both channels
  function automatic logic known(input logic [13:0] a);
    logic [13:0] w;
    w = {a[13:2], 2'b00};
    known = (w == ubd_pkg::ADDR_LINE_CTRL) || (w == ubd_pkg::ADDR_SEC_CTRL)
      || (w == ubd_pkg::ADDR_DIV_HIGH) || (w == ubd_pkg::ADDR_DIV_LOW)
      || (w == ubd_pkg::ADDR_IRQ_STAT) || (w == ubd_pkg::ADDR_IRQ_MASK)
      || (w == ubd_pkg::ADDR_LINE_STAT);
  endfunction

  // one register selected by its word address
  function automatic logic at(input logic [13:0] a, input logic [13:0] r);
    at = ({a[13:2], 2'b00} == r);
  endfunction

  // divisor is the two bytes side by side
  assign divisor_w = {div_hi_q, div_lo_q};
  assign port_on_w = line_q.transmit_enable || line_q.receive_enable;
  // timer only with the port off and timer bit set
  assign timer_w = !port_on_w && sec_q[ubd_pkg::SEC_TIMER_BIT];
  // divider runs for the port or for the timer
  assign run_w = port_on_w || timer_w;
  assign wr_go_w = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_hit_w = known(awaddr_q);
  assign rd_hit_w = known(S_AXI_ARADDR);
  // timeout each divisor cycles in timer use
  assign set_w[ubd_pkg::IRQ_TIMEOUT_BIT] = timer_w && ticks_w.tick;
  // reload event as extra counter
  assign set_w[ubd_pkg::IRQ_RELOAD_BIT] =
    sec_q[ubd_pkg::SEC_DIVIRQ_BIT] && ticks_w.tick;
  assign clr_w = (wr_go_w && at(awaddr_q, ubd_pkg::ADDR_IRQ_STAT)
    && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;
  // cts gate optional, pin low means clear
  assign tx_ok_w = line_q.transmit_enable
    && (!line_q.clear_to_send_gate || !cts_s2_q);

  // read mux, upper bits read zero
  // unmapped words read zero and answer with an error response
  assign rd_data_w =
    at(S_AXI_ARADDR, ubd_pkg::ADDR_LINE_CTRL) ? {24'h000000, line_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_SEC_CTRL) ? {24'h000000, sec_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_DIV_HIGH) ? {24'h000000, div_hi_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_DIV_LOW) ? {24'h000000, div_lo_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_IRQ_STAT) ? {30'h00000000, stat_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_IRQ_MASK) ? {30'h00000000, mask_q} :
    at(S_AXI_ARADDR, ubd_pkg::ADDR_LINE_STAT) ?
      {29'h00000000, timer_w, cts_s2_q, tx_ok_w} : 32'h00000000;

  // one divider serves the bit strobe and the timer; the two never run
  // together, since the timer needs both enables clear
  ubd_divider #(.WIDTH(16)) u_div (
    .clk(MCLK),
    .rst(RST),
    .run(run_w),
    .divisor(divisor_w),
    .ticks(ticks_w)
  );

  // two-flop synchroniser for the cts pin
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
    end else begin
      cts_s1_q <= CTS_N;
      cts_s2_q <= cts_s1_q;
    end
  end

  // write address and data captured independently, either order
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_go_w) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_go_w) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ready is high while the slot is empty and no write response is pending
  always_ff @(posedge MCLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !(S_AXI_AWVALID && S_AXI_AWREADY)
        && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_have_q && !(S_AXI_WVALID && S_AXI_WREADY)
        && !S_AXI_BVALID;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge MCLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= ubd_pkg::AXI_OKAY;
    end else if (wr_go_w) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit_w ? ubd_pkg::AXI_OKAY : ubd_pkg::AXI_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // control registers; byte lane 0 only
  always_ff @(posedge MCLK) begin
    if (RST) begin
      line_q <= ubd_pkg::LINE_CTRL_RESET;
      sec_q <= ubd_pkg::SEC_CTRL_RESET;
      div_hi_q <= ubd_pkg::DIV_RESET;
      div_lo_q <= ubd_pkg::DIV_RESET;
      mask_q <= 2'b00;
    end else if (wr_go_w && wstrb_q[0]) begin
      // writes while enabled are taken as-is; software avoids them
      if (at(awaddr_q, ubd_pkg::ADDR_LINE_CTRL)) begin
        line_q <= wdata_q[7:0];
      end
      if (at(awaddr_q, ubd_pkg::ADDR_SEC_CTRL)) begin
        sec_q <= {6'h00, wdata_q[1:0]};
      end
      if (at(awaddr_q, ubd_pkg::ADDR_DIV_HIGH)) begin
        div_hi_q <= wdata_q[7:0];
      end
      if (at(awaddr_q, ubd_pkg::ADDR_DIV_LOW)) begin
        div_lo_q <= wdata_q[7:0];
      end
      if (at(awaddr_q, ubd_pkg::ADDR_IRQ_MASK)) begin
        mask_q <= wdata_q[1:0];
      end
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      stat_q <= 2'b00;
    end else begin
      stat_q <= (stat_q & ~clr_w) | set_w;
    end
  end

  // read channel, answer one cycle after address taken
  always_ff @(posedge MCLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= ubd_pkg::AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data_w;
      S_AXI_RRESP <= rd_hit_w ? ubd_pkg::AXI_OKAY : ubd_pkg::AXI_SLVERR;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // registered user outputs
  always_ff @(posedge MCLK) begin
    if (RST) begin
      TX_RUN <= 1'b0;
      BIT_TICK <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      TX_RUN <= tx_ok_w;
      BIT_TICK <= ticks_w.bit_tick && port_on_w;
      IRQ <= |(stat_q & mask_q);
    end
  end

  // helper: cycles since last timeout
  logic [16:0] gap_q;
  always_ff @(posedge MCLK) begin
    if (RST || !timer_w || ticks_w.tick) begin
      gap_q <= 17'h00001;
    end else begin
      gap_q <= gap_q + 17'h00001;
    end
  end

  // helper: a whole gap has passed since the timer started; the first
  // tick comes at once after start and has no gap before it
  logic gap_seen_q;
  always_ff @(posedge MCLK) begin
    if (RST || !timer_w) begin
      gap_seen_q <= 1'b0;
    end else if (ticks_w.tick) begin
      gap_seen_q <= 1'b1;
    end
  end

  // timer and divider properties; divisor zero must give the full span
  AST_TIMER_GAP: assert property (@(posedge MCLK)
    disable iff (RST)
    (ticks_w.tick && timer_w && gap_seen_q && $stable(divisor_w))
      |-> (gap_q == ((divisor_w == 16'h0000) ? 17'h10000
        : {1'b0, divisor_w})))
    else $error("timeout spacing differs from divisor");
  AST_TIMER_OFF: assert property (@(posedge MCLK)
    disable iff (RST)
    (!sec_q[ubd_pkg::SEC_TIMER_BIT] && !port_on_w)
      |-> !set_w[ubd_pkg::IRQ_TIMEOUT_BIT])
    else $error("timeout without timer bit");
  AST_PORT_BLOCKS: assert property (@(posedge MCLK)
    disable iff (RST) port_on_w |-> !set_w[ubd_pkg::IRQ_TIMEOUT_BIT])
    else $error("timer event while port enabled");
  AST_TIMEOUT_STICKY: assert property (@(posedge MCLK)
    disable iff (RST)
    set_w[ubd_pkg::IRQ_TIMEOUT_BIT] |=> stat_q[ubd_pkg::IRQ_TIMEOUT_BIT])
    else $error("timeout did not set status");
  AST_TICK_ONE: assert property (@(posedge MCLK)
    disable iff (RST)
    (ticks_w.tick && divisor_w != 16'h0001) |=> !ticks_w.tick)
    else $error("tick longer than one cycle");
  AST_BIT_PORT_ONLY: assert property (@(posedge MCLK)
    disable iff (RST) !port_on_w |=> !BIT_TICK)
    else $error("bit strobe while port disabled");

  // transmitter gate properties
  AST_TX_GATE: assert property (@(posedge MCLK)
    disable iff (RST) (line_q.clear_to_send_gate && cts_s2_q) |=> !TX_RUN)
    else $error("transmitter ran with cts high and gate set");
  AST_TX_EN: assert property (@(posedge MCLK)
    disable iff (RST)
    (line_q.transmit_enable && !line_q.clear_to_send_gate) |=> TX_RUN)
    else $error("transmitter not running when enabled");
  AST_TX_OFF: assert property (@(posedge MCLK)
    disable iff (RST) !line_q.transmit_enable |=> !TX_RUN)
    else $error("transmitter ran while disabled");

  // register and interrupt properties
  AST_RELOAD_IRQ: assert property (@(posedge MCLK)
    disable iff (RST)
    (ticks_w.tick && sec_q[ubd_pkg::SEC_DIVIRQ_BIT])
      |=> stat_q[ubd_pkg::IRQ_RELOAD_BIT])
    else $error("reload did not set status");
  AST_LINE_RESET: assert property (@(posedge MCLK)
    RST |=> (line_q == ubd_pkg::LINE_CTRL_RESET))
    else $error("line control not zero after reset");
  AST_LINE_WRITE: assert property (@(posedge MCLK)
    disable iff (RST)
    (wr_go_w && wstrb_q[0] && at(awaddr_q, ubd_pkg::ADDR_LINE_CTRL))
      |=> (line_q == $past(wdata_q[7:0])))
    else $error("line control write lost");
  AST_LINE_READ: assert property (@(posedge MCLK)
    disable iff (RST)
    (S_AXI_ARVALID && S_AXI_ARREADY
      && at(S_AXI_ARADDR, ubd_pkg::ADDR_LINE_CTRL))
      |=> (S_AXI_RDATA == {24'h000000, $past(line_q)}))
    else $error("line control read back wrong");
  AST_IRQ_LEVEL: assert property (@(posedge MCLK)
    disable iff (RST) (|(stat_q & mask_q)) |=> IRQ)
    else $error("interrupt not raised");
  AST_DIV_BYTES: assert property (@(posedge MCLK)
    disable iff (RST) divisor_w[15:8] == div_hi_q)
    else $error("divisor high byte misplaced");
endmodule

// >>> ubd_remote.sv
/*
  ubd_remote: behavioural far-end receiver that drives the clear-to-send
  pin of the block. assumes the bench changes want and lag after an edge.
*/
module ubd_remote (
  input wire logic clk,
  input wire logic rst,
  input wire logic want,
  input wire logic [3:0] lag,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q; // cycles since the request changed
  logic want_q; // request as last seen
  // the pin follows want only after lag cycles, like a slow far end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      want_q <= 1'b0;
      cts_n <= 1'b1; // not clear to send after reset
    end else if (want != want_q) begin
      want_q <= want;
      cnt_q <= 4'h0;
    end else if (cnt_q < lag) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      cts_n <= ~want_q; // low grants the transmitter
    end
  end
endmodule

// >>> ubd_top_tb.sv
/*
  ubd_top_tb: self-checking bench for the baud divider and timer block.
  assumes ubd_remote stands on the line and drives clear-to-send.
*/
module ubd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0; // 125 MHz system clock
  logic rst = 1'b1; // synchronous reset, high
  logic want = 1'b0; // ask the far end to grant sending
  logic [3:0] lag = 4'h3; // far end answers slowly
  logic cts_n;
  logic [13:0] awaddr = 14'h0000;
  logic [13:0] araddr = 14'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_run, bit_tick, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0; // edge count, updated late so reads at an edge agree
  int t1, t2;
  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  ubd_remote i_far (.clk(mclk), .rst(rst), .want(want), .lag(lag),
    .cts_n(cts_n));
  ubd_top i_dut (
    .MCLK(mclk),
    .RST(rst),
    .CTS_N(cts_n),
    .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready),
    .TX_RUN(tx_run),
    .BIT_TICK(bit_tick),
    .IRQ(irq)
  );
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask
  // a wait that ran out ends the run
  task automatic lost(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected answer seen none", what);
    stop_test();
  endtask
  // write one byte register; address and data offered together
  task automatic axi_wr(input logic [13:0] a, input logic [7:0] d,
                        input logic [1:0] er = ubd_pkg::AXI_OKAY);
    logic aw_ok, w_ok, b_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge mclk);
      n++;
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        b_ok = 1'b1;
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
      if (n > 40) lost("write");
    end
    @(posedge mclk); // spacing so no signal is set twice at one edge
  endtask
  // read one byte register and compare data and response
  task automatic axi_rd(input logic [13:0] a, input logic [7:0] d,
                        input logic [1:0] er = ubd_pkg::AXI_OKAY);
    logic ar_ok, r_ok;
    int n;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(posedge mclk);
      n++;
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        r_ok = 1'b1;
        rready <= 1'b0;
        chk("rdata", {24'h0, d}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
      if (n > 40) lost("read");
    end
    @(posedge mclk);
  endtask
  // bounded wait for a level on irq (0), bit_tick (1) or tx_run (2)
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          output int at, input bit must);
    logic v;
    at = -1;
    for (int i = 0; i < lim && at < 0; i++) begin
      @(posedge mclk);
      v = (sel == 0) ? irq : (sel == 1) ? bit_tick : tx_run;
      if (v === lvl) at = cyc;
    end
    if (must && at < 0) lost("wait");
  endtask
  // reset values, read-back, unmapped address
  task automatic s_regs;
    axi_rd(ubd_pkg::ADDR_LINE_CTRL, 8'h00);
    axi_rd(ubd_pkg::ADDR_DIV_LOW, 8'h00);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h3F);
    axi_rd(ubd_pkg::ADDR_LINE_CTRL, 8'h3F);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h00);
    axi_wr(14'h0100, 8'h55, ubd_pkg::AXI_SLVERR);
    axi_rd(14'h0100, 8'h00, ubd_pkg::AXI_SLVERR);
  endtask
  // transmit enable with and without the clear-to-send gate
  task automatic s_tx;
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h80);
    wait_for(2, 1'b1, 20, t1, 1);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h00);
    wait_for(2, 1'b0, 20, t1, 1);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h20); // while disabled
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'hA0);
    wait_for(2, 1'b1, 30, t1, 0);
    chk("tx_run gated", 32'hFFFFFFFF, t1);
    want <= 1'b1;
    wait_for(2, 1'b1, 30, t1, 1);
    want <= 1'b0;
    wait_for(2, 1'b0, 30, t1, 1);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h00);
  endtask
  // timer use: disabled port, load divisor, then timer bit
  task automatic s_timer;
    axi_wr(ubd_pkg::ADDR_DIV_HIGH, 8'h00);
    axi_wr(ubd_pkg::ADDR_DIV_LOW, 8'h40);
    axi_wr(ubd_pkg::ADDR_IRQ_MASK, 8'h01);
    wait_for(0, 1'b1, 150, t1, 0);
    chk("irq without timer bit", 32'hFFFFFFFF, t1);
    axi_wr(ubd_pkg::ADDR_SEC_CTRL, 8'h01);
    wait_for(0, 1'b1, 200, t1, 1);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h01);
    wait_for(0, 1'b1, 200, t2, 1);
    chk("timeout spacing", 32'h00000040, t2 - t1);
    axi_wr(ubd_pkg::ADDR_SEC_CTRL, 8'h00);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h01);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axi_rd(ubd_pkg::ADDR_IRQ_STAT, 8'h00);
  endtask
  // port enabled: bit strobe rate, reload interrupt, no timeout
  task automatic s_port;
    axi_wr(ubd_pkg::ADDR_SEC_CTRL, 8'h02);
    axi_wr(ubd_pkg::ADDR_DIV_HIGH, 8'h01);
    axi_wr(ubd_pkg::ADDR_DIV_LOW, 8'h02);
    axi_wr(ubd_pkg::ADDR_IRQ_MASK, 8'h02);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h40);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h03);
    wait_for(1, 1'b1, 4200, t1, 1);
    wait_for(1, 1'b1, 4200, t2, 1);
    chk("bit tick spacing", 32'h00001020, t2 - t1);
    axi_rd(ubd_pkg::ADDR_IRQ_STAT, 8'h02);
    chk("reload irq", 32'h00000001, {31'h0, irq});
    axi_rd(ubd_pkg::ADDR_LINE_CTRL, 8'h40);
    axi_wr(ubd_pkg::ADDR_LINE_CTRL, 8'h00);
  endtask
  // divisor zero in timer use gives the largest span
  task automatic s_zero;
    axi_wr(ubd_pkg::ADDR_IRQ_MASK, 8'h01);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h03);
    axi_wr(ubd_pkg::ADDR_DIV_HIGH, 8'h00);
    axi_wr(ubd_pkg::ADDR_DIV_LOW, 8'h00);
    axi_wr(ubd_pkg::ADDR_SEC_CTRL, 8'h01);
    wait_for(0, 1'b1, 20, t1, 1);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h01);
    wait_for(0, 1'b1, 66000, t2, 1);
    chk("zero divisor spacing", 32'h00010000, t2 - t1);
    axi_wr(ubd_pkg::ADDR_SEC_CTRL, 8'h00);
    axi_wr(ubd_pkg::ADDR_IRQ_STAT, 8'h01);
    chk("irq cleared after zero", 32'h0, {31'h0, irq});
  endtask
  // main sequence: reset ten cycles, first request two edges later
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    s_regs();
    s_tx();
    s_timer();
    s_port();
    s_zero();
    stop_test();
  end
endmodule
